// ===== odt_ctrl.sv
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
module odt_ctrl
(
    // Clock and control
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        ce,
    // Memory pins, CK domain
    input  wire logic        ck,
    input  wire logic        odt,
    input  wire logic        cmd_write,
    input  wire logic        cmd_read,
    input  wire logic        cmd_bc4,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Termination outputs
    output odt_pkg::rtt_sel_t rtt_sel,
    output logic      [2:0]  rtt_value
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    odt_pkg::pins_t pins_meta;
    odt_pkg::pins_t pins_sync;
    logic           ck_prev;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pins_meta <= 5'h00;
            pins_sync <= 5'h00;
            ck_prev   <= 1'b0;
        end
        else if (ce)
        begin
            pins_meta <= '{ck: ck, odt: odt, wr: cmd_write, rd: cmd_read, bc4: cmd_bc4};
            pins_sync <= pins_meta;
            ck_prev   <= pins_sync.ck;
        end
    end

    // Pins are stable around CK rise, so one clk_sys late still sees them
    wire ck_tick = pins_sync.ck & ~ck_prev;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [2:0]    mr1_nom;
    logic [2:0]    mr2_wr;
    logic [2:0]    mr5_park;
    odt_pkg::cfg_t cfg;
    logic          hold_err;
    logic          nom_on;

    wire apb_setup  = psel & ~penable & ~pready;
    wire apb_done   = psel & penable & pready;
    wire apb_wr     = apb_done & pwrite;
    wire sel_mr1    = paddr == odt_pkg::ADDR_MR1;
    wire sel_mr2    = paddr == odt_pkg::ADDR_MR2;
    wire sel_mr5    = paddr == odt_pkg::ADDR_MR5;
    wire sel_cfg    = paddr == odt_pkg::ADDR_CONFIG;
    wire sel_status = paddr == odt_pkg::ADDR_STATUS;
    wire mapped     = sel_mr1 | sel_mr2 | sel_mr5 | sel_cfg | sel_status;

    // Dynamic termination needs a write value and a running DLL
    wire dyn_en = (|mr2_wr) & ~cfg.dll_off;

    wire [31:0] rd_mr1    = {21'h000000, mr1_nom, 8'h00};
    wire [31:0] rd_mr2    = {20'h00000, mr2_wr, 9'h000};
    wire [31:0] rd_mr5    = {23'h000000, mr5_park, 6'h00};
    wire [31:0] rd_cfg    = {9'h000, cfg};
    wire [31:0] rd_status = {27'h0000000, nom_on, hold_err, dyn_en, rtt_sel};
    wire [31:0] rd_mux    = sel_mr1 ? rd_mr1 :
                            sel_mr2 ? rd_mr2 :
                            sel_mr5 ? rd_mr5 :
                            sel_cfg ? rd_cfg :
                            sel_status ? rd_status : 32'h00000000;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (ce)
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~mapped;
            prdata  <= apb_setup ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mr1_nom  <= 3'h0;
            mr2_wr   <= 3'h0;
            mr5_park <= 3'h0;
            cfg      <= odt_pkg::CFG_RESET;
        end
        else if (ce && apb_wr)
        begin
            if (sel_mr1)
                mr1_nom <= pwdata[odt_pkg::MR1_NOM_LSB +: 3];
            if (sel_mr2)
                mr2_wr <= pwdata[odt_pkg::MR2_WR_LSB +: 3];
            if (sel_mr5)
                mr5_park <= pwdata[odt_pkg::MR5_PARK_LSB +: 3];
            if (sel_cfg)
                cfg <= pwdata[22:0];
        end
    end

    // ------------------------------------------------------------------
    // Latencies in CK cycles
    // ------------------------------------------------------------------
    wire [6:0] pre_lat  = odt_pkg::PRE_LAT_1CK + {6'h00, cfg.pre2};
    wire [6:0] wl       = 7'(cfg.cwl) + 7'(cfg.al) + 7'(cfg.pl);
    wire [6:0] rl       = 7'(cfg.cl) + 7'(cfg.al) + 7'(cfg.pl);
    wire [6:0] dodtl    = wl - pre_lat;
    wire [6:0] odtl_cnw = wl - pre_lat;
    wire [6:0] cwn4_add = (cfg.crc ? odt_pkg::CWN4_CRC_ON : odt_pkg::CWN4_CRC_OFF)
                          + {6'h00, cfg.pre2};
    wire [6:0] cwn8_add = (cfg.crc ? odt_pkg::CWN8_CRC_ON : odt_pkg::CWN8_CRC_OFF)
                          + {6'h00, cfg.pre2};
    wire [6:0] rodt_off = rl - pre_lat;
    // BL/2 plus preamble term already folded into the base lengths
    wire [6:0] rd4_len  = odt_pkg::READ_BC4_LEN + {6'h00, cfg.pre2} + {6'h00, cfg.crc};
    wire [6:0] rd8_len  = odt_pkg::READ_BL8_LEN + {6'h00, cfg.pre2} + {6'h00, cfg.crc};

    // ------------------------------------------------------------------
    // CK-cycle history of pin events
    // ------------------------------------------------------------------
    logic [odt_pkg::HIST_DEPTH-1:0] odt_hist;
    logic [odt_pkg::HIST_DEPTH-1:0] wr_hist;
    logic [odt_pkg::HIST_DEPTH-1:0] rd_hist;
    logic [odt_pkg::HIST_DEPTH-1:0] bc4_hist;

    wire cmd_is_bc4 = (cfg.burst == odt_pkg::BURST_BC4) |
                      ((cfg.burst == odt_pkg::BURST_OTF) & pins_sync.bc4);
    // A write with dynamic termination off is not entered in the write history
    wire wr_take    = pins_sync.wr & dyn_en;

    wire [odt_pkg::HIST_DEPTH-1:0] next_odt_hist = {odt_hist[odt_pkg::HIST_DEPTH-2:0],
                                                    pins_sync.odt};
    wire [odt_pkg::HIST_DEPTH-1:0] next_wr_hist  = {wr_hist[odt_pkg::HIST_DEPTH-2:0],
                                                    wr_take};
    wire [odt_pkg::HIST_DEPTH-1:0] next_rd_hist  = {rd_hist[odt_pkg::HIST_DEPTH-2:0],
                                                    pins_sync.rd};
    wire [odt_pkg::HIST_DEPTH-1:0] next_bc4_hist = {bc4_hist[odt_pkg::HIST_DEPTH-2:0],
                                                    cmd_is_bc4};

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            odt_hist <= '0;
            wr_hist  <= '0;
            rd_hist  <= '0;
            bc4_hist <= '0;
        end
        else if (ce && ck_tick)
        begin
            odt_hist <= next_odt_hist;
            wr_hist  <= next_wr_hist;
            rd_hist  <= next_rd_hist;
            bc4_hist <= next_bc4_hist;
        end
    end

    // ------------------------------------------------------------------
    // Window decode over the history
    // ------------------------------------------------------------------
    function automatic logic [6:0] odt_l_cwn(input logic is_bc4);
        odt_l_cwn = odtl_cnw + (is_bc4 ? cwn4_add : cwn8_add);
    endfunction : odt_l_cwn

    logic wr_window;
    logic rd_window;

    always_comb
    begin
        logic [6:0] idx;
        logic [6:0] wr_end;
        logic [6:0] rd_end;
        wr_window = 1'b0;
        rd_window = 1'b0;
        idx       = 7'h00;
        wr_end    = 7'h00;
        rd_end    = 7'h00;
        for (int i = 0; i < odt_pkg::HIST_DEPTH; i++)
        begin
            idx    = 7'(i);
            wr_end = odt_l_cwn(next_bc4_hist[i]);
            rd_end = rodt_off + (next_bc4_hist[i] ? rd4_len : rd8_len);
            if (next_wr_hist[i] && idx >= odtl_cnw && idx < wr_end)
                wr_window = 1'b1;
            if (next_rd_hist[i] && idx >= rodt_off && idx < rd_end)
                rd_window = 1'b1;
        end
    end

    // Nominal request follows ODT delayed by the direct latency
    wire nom_req = next_odt_hist[dodtl] & (|mr1_nom);
    wire park_ok = |mr5_park;

    // Driver release ends the read window, so read disable outranks all
    wire odt_pkg::rtt_sel_t next_sel = rd_window ? odt_pkg::RTT_OFF :
                                       wr_window ? odt_pkg::RTT_WR  :
                                       nom_req   ? odt_pkg::RTT_NOM :
                                       park_ok   ? odt_pkg::RTT_PARK :
                                                   odt_pkg::RTT_OFF;
    wire [2:0] next_value = (next_sel == odt_pkg::RTT_WR)   ? mr2_wr  :
                            (next_sel == odt_pkg::RTT_NOM)  ? mr1_nom :
                            (next_sel == odt_pkg::RTT_PARK) ? mr5_park : 3'h0;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rtt_sel   <= odt_pkg::RTT_OFF;
            rtt_value <= 3'h0;
            nom_on    <= 1'b0;
        end
        else if (ce && ck_tick)
        begin
            rtt_sel   <= next_sel;
            rtt_value <= next_value;
            nom_on    <= nom_req;
        end
    end

    // ------------------------------------------------------------------
    // ODT hold time monitor
    // ------------------------------------------------------------------
    // Base figures plus one with the 2-clock preamble are checked; CRC margins
    // are the controller's concern, so a short CRC extension is not flagged.
    logic       hold_active;
    logic [7:0] hold_cnt;
    logic       odt_prev;

    wire [7:0] odth_min   = (cfg.burst == odt_pkg::BURST_BC4 ? odt_pkg::ODTH4_BASE
                                                              : odt_pkg::ODTH8_BASE)
                            + {7'h00, cfg.pre2};
    // A WRITE restarts the count only while ODT is held high
    wire       hold_start = ck_tick & pins_sync.odt & (~odt_prev | pins_sync.wr);
    wire       hold_end   = ck_tick & hold_active & ~pins_sync.odt & ~hold_start;
    wire       hold_short = hold_end & (hold_cnt < odth_min);
    wire       err_clear  = apb_wr & sel_status & pwdata[3];

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            hold_active <= 1'b0;
            hold_cnt    <= 8'h00;
            odt_prev    <= 1'b0;
            hold_err    <= 1'b0;
        end
        else if (ce)
        begin
            if (ck_tick)
                odt_prev <= pins_sync.odt;
            if (hold_start)
            begin
                hold_active <= 1'b1;
                hold_cnt    <= 8'h01;
            end
            else if (hold_end)
                hold_active <= 1'b0;
            else if (ck_tick && hold_active && hold_cnt != 8'hFF)
                hold_cnt <= hold_cnt + 8'h01;
            // A new violation beats a clear in the same cycle
            if (hold_short)
                hold_err <= 1'b1;
            else if (err_clear)
                hold_err <= 1'b0;
        end
    end

endmodule : odt_ctrl

// ===== odt_pkg.sv
// Operation
// - Hold time counts from first ODT high or a WRITE to first ODT low.
// - No termination while read data is driven; it returns after the postamble.
// - Dynamic termination is on when the write termination field is nonzero.
// - Nominal, write and park values come from MR1[10:8], MR2[11:9], MR5[8:6].
// - Without writes: nominal follows ODT with its latencies, park while ODT is low.
// - With dynamic termination on, write value starts ODTLcnw after any WRITE.
// - Write value ends ODTLcwn4 after a BC4 WRITE, ODTLcwn8 after BL8.
// - ODTLcnw is WL minus 2 with 1-clock preamble, WL minus 3 with 2-clock.
// - ODTLcwn4 adds 4/5, or 7/8 with CRC; ODTLcwn8 adds 6/7, or 7/8 with CRC.
// - Dynamic termination switching is disabled in DLL-off mode.
// - DODTLon and DODTLoff are CWL+AL+PL minus 2 or 3 by preamble mode.
// - Priority: read disable, then write, then nominal, then park termination.
// - After READ, off from RL-2/3 for BL/2 plus 2/3, plus 1 with CRC.
package odt_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MR1    = 8'h00;
    localparam logic [7:0] ADDR_MR2    = 8'h04;
    localparam logic [7:0] ADDR_MR5    = 8'h08;
    localparam logic [7:0] ADDR_CONFIG = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Field positions inside the mode registers
    localparam int MR1_NOM_LSB  = 8;
    localparam int MR2_WR_LSB   = 9;
    localparam int MR5_PARK_LSB = 6;

    // Burst modes
    localparam logic [1:0] BURST_BL8 = 2'h0;
    localparam logic [1:0] BURST_BC4 = 2'h1;
    localparam logic [1:0] BURST_OTF = 2'h2;

    // Latency history depth in CK cycles
    localparam int HIST_DEPTH = 128;

    // Latency offsets and window lengths for 1-clock preamble, CRC off / on; 2-clock adds one
    localparam logic [6:0] CWN4_CRC_OFF = 7'h04;
    localparam logic [6:0] CWN4_CRC_ON  = 7'h07;
    localparam logic [6:0] CWN8_CRC_OFF = 7'h06;
    localparam logic [6:0] CWN8_CRC_ON  = 7'h07;
    localparam logic [6:0] PRE_LAT_1CK  = 7'h02;
    localparam logic [6:0] READ_BC4_LEN = 7'h04;
    localparam logic [6:0] READ_BL8_LEN = 7'h06;
    localparam logic [7:0] ODTH4_BASE   = 8'h04;
    localparam logic [7:0] ODTH8_BASE   = 8'h06;

    typedef enum logic [1:0]
    {
        RTT_OFF  = 2'b00,
        RTT_PARK = 2'b01,
        RTT_NOM  = 2'b10,
        RTT_WR   = 2'b11
    } rtt_sel_t;

    typedef struct packed
    {
        logic [1:0] burst;
        logic       dll_off;
        logic       crc;
        logic       pre2;
        logic [4:0] cl;
        logic [2:0] pl;
        logic [4:0] al;
        logic [4:0] cwl;
    } cfg_t;

    localparam cfg_t CFG_RESET = 23'h000000;

    typedef struct packed
    {
        logic ck;
        logic odt;
        logic wr;
        logic rd;
        logic bc4;
    } pins_t;

endpackage : odt_pkg

// ===== odt_ctrl_chk.sv
`timescale 1ns/100ps
module odt_ctrl_chk
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic              ce,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Termination
    input wire odt_pkg::rtt_sel_t rtt_sel,
    input wire logic [2:0]        rtt_value
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset || !ce);

    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    a_off_value: assert property ((rtt_sel == odt_pkg::RTT_OFF) == (rtt_value == 3'h0))
        else $error("termination value disagrees with selection");
    a_sel_steady: assert property ($changed(rtt_sel) |=> $stable(rtt_sel) [*8])
        else $error("termination selection changed twice within a CK");
    a_value_steady: assert property ($changed(rtt_value) |=> $stable(rtt_value) [*8])
        else $error("termination value changed twice within a CK");
    a_reset_clears: assert property (@(posedge clk_sys) disable iff (1'b0)
        reset && ce |=> rtt_sel == odt_pkg::RTT_OFF && !pready)
        else $error("reset did not clear outputs");
endmodule : odt_ctrl_chk

bind odt_ctrl odt_ctrl_chk i_odt_ctrl_chk
(
    .clk_sys, .reset, .ce, .psel, .penable, .prdata, .pready, .pslverr, .rtt_sel, .rtt_value
);

// ===== ddr_ctrl_model.sv
`timescale 1ns/100ps
module ddr_ctrl_model
(
    // Requests from the bench
    input wire logic       odt_req,
    input wire logic       wr_req,
    input wire logic       rd_req,
    input wire logic       bc4_req,
    // Pins toward the device
    output odt_pkg::pins_t pins
);
    logic ck_q  = 1'b0;
    logic odt_q = 1'b0;
    logic wr_q  = 1'b0;
    logic rd_q  = 1'b0;
    logic bc4_q = 1'b0;

    // CK runs free, as a memory clock does
    always #80 ck_q = ~ck_q;

    // Launch on the falling edge so every pin is settled around each rise
    always @(negedge ck_q)
    begin
        odt_q <= odt_req;
        wr_q  <= wr_req;
        rd_q  <= rd_req;
        // Burst select means nothing without a command, so it wanders
        bc4_q <= (wr_req || rd_req) ? bc4_req : ~bc4_q;
    end

    assign pins = '{ck: ck_q, odt: odt_q, wr: wr_q, rd: rd_q, bc4: bc4_q};
endmodule : ddr_ctrl_model

// ===== tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
    logic              clk_sys = 1'b0;
    logic              reset   = 1'b1;
    logic              ce      = 1'b1;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [7:0]        paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    odt_pkg::rtt_sel_t rtt_sel;
    logic [2:0]        rtt_value;
    logic              odt_req = 1'b0;
    logic              wr_req  = 1'b0;
    logic              rd_req  = 1'b0;
    logic              bc4_req = 1'b0;
    odt_pkg::pins_t    pins;
    logic [31:0]       q;
    logic              e;
    int                fail_count = 0;
    int                n_compared = 0;

    always #5 clk_sys = ~clk_sys;

    ddr_ctrl_model i_ddr_ctrl_model (.odt_req, .wr_req, .rd_req, .bc4_req, .pins);
    odt_ctrl i_odt_ctrl (.clk_sys, .reset, .ce, .ck(pins.ck), .odt(pins.odt),
        .cmd_write(pins.wr), .cmd_read(pins.rd), .cmd_bc4(pins.bc4), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rtt_sel, .rtt_value);

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] cfg(input logic p2, crc, dll, input logic [1:0] bm);
        // CWL 9, AL 0, PL 0, CL 11
        return {9'h000, bm, dll, crc, p2, 5'h0B, 3'h0, 5'h00, 5'h09};
    endfunction : cfg

    function automatic logic [2:0] val(input odt_pkg::rtt_sel_t s);
        case (s)
            odt_pkg::RTT_PARK: return 3'h3;
            odt_pkg::RTT_NOM:  return 3'h2;
            odt_pkg::RTT_WR:   return 3'h5;
            default:           return 3'h0;
        endcase
    endfunction : val

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Command at tick 0, ODT high for ot ticks; s expected in [lo, hi), park elsewhere
    task automatic run(input logic w, r, b, input int ot, lo, hi, input odt_pkg::rtt_sel_t s);
        odt_pkg::rtt_sel_t x;
        @(posedge pins.ck);
        @(posedge clk_sys);
        wr_req  <= w;
        rd_req  <= r;
        bc4_req <= b;
        odt_req <= (ot > 0);
        @(posedge pins.ck);
        @(posedge clk_sys);
        wr_req  <= 1'b0;
        rd_req  <= 1'b0;
        // Requests reach the pins at the next CK fall, so run two ticks ahead
        odt_req <= (ot > 1);
        for (int t = 0; t < 18; t++)
        begin
            @(negedge pins.ck);
            x = (t >= lo && t < hi) ? s : odt_pkg::RTT_PARK;
            `CHK(rtt_sel, x)
            `CHK(rtt_value, val(x))
            @(posedge clk_sys);
            odt_req <= (t + 2 < ot);
        end
    endtask : run

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic test_regs;
        apb(1'b0, odt_pkg::ADDR_MR2, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b1, odt_pkg::ADDR_MR1, 32'hFFFFFFFF);
        apb(1'b0, odt_pkg::ADDR_MR1, 32'h0);
        `CHK(q, 32'h00000700)
        apb(1'b0, 8'h14, 32'h0);
        `CHK({e, q}, 33'h100000000)
        apb(1'b1, odt_pkg::ADDR_CONFIG, 32'hFFFFFFFF);
        apb(1'b0, odt_pkg::ADDR_CONFIG, 32'h0);
        `CHK(q, 32'h007FFFFF)
        apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(1'b0, 1'b0, 1'b0, 2'h0));
        apb(1'b1, odt_pkg::ADDR_MR1, 32'h00000200);
        apb(1'b1, odt_pkg::ADDR_MR2, 32'h00000A00);
        apb(1'b1, odt_pkg::ADDR_MR5, 32'h000000C0);
        apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[2], 1'b1)
    endtask : test_regs

    task automatic test_write;
        int cnw;
        int cwn;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(i[0], i[1], 1'b0, {1'b0, i[2]}));
            cnw = 7 - i[0];
            cwn = cnw + i[0] + (i[1] ? 7 : (i[2] ? 4 : 6));
            run(1'b1, 1'b0, 1'b0, 0, cnw, cwn, odt_pkg::RTT_WR);
        end
        apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(1'b0, 1'b0, 1'b0, 2'h2));
        run(1'b1, 1'b0, 1'b1, 0, 7, 11, odt_pkg::RTT_WR);
    endtask : test_write

    task automatic test_nominal;
        apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(1'b0, 1'b0, 1'b0, 2'h0));
        // Writes with ODT low must not have flagged a hold error
        apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[3], 1'b0)
        apb(1'b1, odt_pkg::ADDR_STATUS, 32'h00000008);
        run(1'b0, 1'b0, 1'b0, 8, 7, 15, odt_pkg::RTT_NOM);
        apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[3], 1'b0)
        apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(1'b1, 1'b0, 1'b0, 2'h0));
        run(1'b0, 1'b0, 1'b0, 8, 6, 14, odt_pkg::RTT_NOM);
        apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(1'b0, 1'b0, 1'b0, 2'h0));
        // Too short on purpose: hold error must latch
        run(1'b0, 1'b0, 1'b0, 2, 7, 9, odt_pkg::RTT_NOM);
        apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[3], 1'b1)
        apb(1'b1, odt_pkg::ADDR_STATUS, 32'h00000008);
        apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[3], 1'b0)
    endtask : test_nominal

    task automatic test_read;
        int lo;
        int hi;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(i[0], i[1], 1'b0, {1'b0, i[2]}));
            lo = 9 - i[0];
            hi = lo + (i[2] ? 4 : 6) + i[0] + i[1];
            run(1'b0, 1'b1, 1'b0, 0, lo, hi, odt_pkg::RTT_OFF);
        end
    endtask : test_read

    task automatic test_dyn_off;
        apb(1'b1, odt_pkg::ADDR_MR2, 32'h0);
        apb(1'b0, odt_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[2], 1'b0)
        run(1'b1, 1'b0, 1'b0, 0, 0, 0, odt_pkg::RTT_PARK);
        apb(1'b1, odt_pkg::ADDR_MR2, 32'h00000A00);
        apb(1'b1, odt_pkg::ADDR_CONFIG, cfg(1'b0, 1'b0, 1'b1, 2'h0));
        run(1'b1, 1'b0, 1'b0, 0, 0, 0, odt_pkg::RTT_PARK);
    endtask : test_dyn_off

    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        test_regs();
        test_write();
        test_nominal();
        test_read();
        test_dyn_off();
        results();
    end

    // About 22 runs of 20 CK each plus bus traffic; generous margin
    initial
    begin
        #400us;
        fail_count++;
        results();
    end
endmodule : tb_top
